//--- bench/tcs_conv_model.sv
// converter model answering each request after LAT cycles
// assumes one request at a time on sys_clk
`default_nettype none
module tcs_conv_model #(
    parameter int LAT = 4
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire tcs_pkg::tcs_conv_req_type conv_req,
    input wire logic [11:0] raw,
    output logic busy,
    output tcs_pkg::tcs_conv_rsp_type conv_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    import tcs_pkg::*;
    int cnt_q;
    tcs_chan_type ch_q;
    // ****************
    // conversion timer
    // ****************
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 0;
            ch_q <= 2'h0;
        end else if (conv_req.start) begin
            cnt_q <= LAT;
            ch_q <= conv_req.chan;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign busy = cnt_q != 0;
    // data off the done cycle is inverted so a stale value never matches
    assign conv_rsp = '{cnt_q == 1, ch_q, (cnt_q == 1) ? raw : ~raw};
endmodule
`default_nettype wire

//--- bench/tcs_top_asserts.sv
// port assertions for the scheduler top
// assumes it is bound into tcs_top, one clock domain
`default_nettype none
module tcs_top_asserts (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire tcs_pkg::tcs_adc_stat_type adc_stat,
    input wire tcs_pkg::tcs_conv_req_type conv_req,
    input wire logic [1:0] rd_remote_sel,
    input wire logic [1:0] rd_remote_en,
    input wire logic temp_sensor_pd,
    input wire logic dac_hiz,
    input wire logic overtemp_alert,
    input wire logic [1:0] oc_cmp_trip,
    input wire logic [1:0] oc_supply_low,
    input wire logic [1:0] oc_flag_clr,
    input wire logic [1:0] overcurrent_flag_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import tcs_pkg::*;
    // ****************
    // checks
    // ****************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    chk_start_pulse: assert property (conv_req.start |=> !conv_req.start)
        else $error("start longer than one cycle");
    chk_start_cause: assert property (conv_req.start |-> $past(!adc_stat.busy
        || (adc_stat.mode == ADC_MODE_SINGLE && adc_stat.conv_done) || (adc_stat.mode == ADC_MODE_SEQ && adc_stat.seq_slot)))
        else $error("start while converter not free");
    chk_remote_en: assert property (1 |=> rd_remote_en ==
        (($past(adc_stat.mode) == ADC_MODE_SINGLE) ? $past(rd_remote_sel) : 2'h0))
        else $error("remote read enable wrong");
    chk_hiz_pd: assert property (temp_sensor_pd |=> !dac_hiz)
        else $error("dac high-z while sensor down");
    chk_alert_hiz: assert property ($rose(dac_hiz) |-> overtemp_alert)
        else $error("high-z without alert");
    chk_oc_trip: assert property (|oc_cmp_trip |-> ##3 (overcurrent_flag_out & $past(oc_cmp_trip, 3))
        == $past(oc_cmp_trip, 3)) else $error("trip did not raise flag");
    chk_oc_supply: assert property (|oc_supply_low |-> ##3 (overcurrent_flag_out & $past(oc_supply_low, 3))
        == $past(oc_supply_low, 3)) else $error("low supply did not raise flag");
    chk_flag_latched: assert property (##1 ($past(overcurrent_flag_out) & ~$past(oc_flag_clr)
        & ~overcurrent_flag_out) == 2'h0) else $error("flag dropped without clear");
    cover property (conv_req.start && conv_req.chan == 2'h2);
    cover property ($rose(dac_hiz));
    cover property (overcurrent_flag_out == 2'h2);
endmodule
bind tcs_top tcs_top_asserts u_tcs_top_asserts (.sys_clk(sys_clk), .nrst(nrst), .adc_stat(adc_stat),
    .conv_req(conv_req), .rd_remote_sel(rd_remote_sel), .rd_remote_en(rd_remote_en),
    .temp_sensor_pd(temp_sensor_pd), .dac_hiz(dac_hiz), .overtemp_alert(overtemp_alert),
    .oc_cmp_trip(oc_cmp_trip), .oc_supply_low(oc_supply_low), .oc_flag_clr(oc_flag_clr),
    .overcurrent_flag_out(overcurrent_flag_out));
`default_nettype wire

//--- bench/tcs_top_tb.sv
// self-checking bench for tcs_top with a 30 cycle period
// assumes tcs_conv_model as the converter
`default_nettype none
module tcs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tcs_pkg::*;
    typedef logic [11:0] tcs_w_type;
    // rows: raw, offset, expected result, dac code
    localparam tcs_w_type ROWS [4][4] = '{'{12'h064, 12'h004, 12'h068, 12'h5A3},
        '{12'h100, 12'hFFC, 12'h0FC, 12'hFFF}, '{12'h7FE, 12'h010, 12'h7FF, 12'h000},
        '{12'h800, 12'hFFC, 12'h800, 12'h3C3}};
    logic sys_clk = 1'h0, nrst = 1'h0, xbusy = 1'h0, xdone = 1'h0, slot = 1'h0, pd = 1'h0, aclr = 1'h0;
    logic busy, hiz, alert;
    tcs_mode_type mode = ADC_MODE_SINGLE;
    logic [11:0] raw = '0, off = '0;
    logic [1:0] sel = '0, trip = '0, uv = '0, oclr = '0, en, flag;
    logic [3:0][11:0] dac = '0, core;
    logic [2:0][11:0] res;
    tcs_adc_stat_type stat;
    tcs_conv_req_type req;
    tcs_conv_rsp_type rsp;
    tcs_chan_type last;
    int fail_count = 0, n_compared = 0, ns = 0, n0 = 0;
    assign stat = '{busy | xbusy, rsp.done | xdone, slot, mode};
    always #2.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        if (req.start === 1'b1) begin
            ns++;
            last = req.chan;
        end
    end
    tcs_top #(.PERIOD_CYC(30)) u_tcs_top (.sys_clk(sys_clk), .nrst(nrst), .adc_stat(stat), .conv_req(req),
        .conv_rsp(rsp), .temp_offset(off), .temp_result(res), .rd_remote_sel(sel), .rd_remote_en(en),
        .dac_code(dac), .dac_core_code(core), .temp_sensor_pd(pd), .dac_hiz(hiz), .overtemp_alert(alert),
        .overtemp_alert_clr(aclr), .oc_cmp_trip(trip), .oc_supply_low(uv), .oc_flag_clr(oclr),
        .overcurrent_flag_out(flag));
    tcs_conv_model u_tcs_conv_model (.sys_clk(sys_clk), .nrst(nrst), .conv_req(req), .raw(raw),
        .busy(busy), .conv_rsp(rsp));
    // ****************
    // tasks and tests
    // ****************
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        tick(5);
        nrst = 1'h1;
        tick(12);
        cmp({8'h0, 2'(ns), last}, 12'h004);
        for (int i = 0; i < 4; i++) begin
            raw = ROWS[i][0];
            off = ROWS[i][1];
            for (int j = 0; j < 4; j++) dac[j] = ROWS[i][3] ^ 12'(j);
            n0 = ns;
            tick(60);
            cmp(12'(ns - n0), 12'h006);
            for (int j = 0; j < 3; j++) cmp(res[j], ROWS[i][2]);
            for (int j = 0; j < 4; j++) cmp(core[j], ~(ROWS[i][3] ^ 12'(j)));
        end
        $display("test rows done");
        raw = 12'h258;
        off = '0;
        tick(40);
        cmp({10'h0, hiz, alert}, 12'h001);
        aclr = 1'h1;
        tick(1);
        aclr = 1'h0;
        cmp({10'h0, hiz, alert}, 12'h000);
        raw = 12'h259;
        tick(40);
        cmp({10'h0, hiz, alert}, 12'h003);
        pd = 1'h1;
        tick(2);
        cmp({11'h0, hiz}, 12'h000);
        trip = 2'h1;
        tick(1);
        trip = 2'h0;
        tick(8);
        cmp({10'h0, flag}, 12'h001);
        oclr = 2'h1;
        tick(1);
        oclr = 2'h0;
        uv = 2'h2;
        tick(1);
        uv = 2'h0;
        tick(8);
        cmp({10'h0, flag}, 12'h002);
        $display("test thermal and overcurrent done");
        sel = 2'h3;
        nrst = 1'h0;
        tick(2);
        cmp({res[0][9:0], flag}, 12'h000);
        nrst = 1'h1;
        xbusy = 1'h1;
        mode = ADC_MODE_SEQ;
        n0 = ns;
        tick(31);
        cmp({8'h0, 2'(ns - n0), en}, 12'h000);
        slot = 1'h1;
        tick(1);
        slot = 1'h0;
        tick(5);
        cmp({8'h0, 2'(ns - n0), last}, 12'h004);
        mode = ADC_MODE_SINGLE;
        xdone = 1'h1;
        tick(1);
        xdone = 1'h0;
        tick(1);
        cmp({8'h0, 2'(ns - n0), last}, 12'h009);
        cmp({10'h0, en}, 12'h003);
        $display("test scheduler done");
        give_verdict();
    end
    initial begin
        #20000;
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire

//--- hdl/tcs_arbiter.sv
// fixed priority picker over pending temperature requests
// assumes requests are same-clock levels; purely combinational
`default_nettype none

module tcs_arbiter #(
    parameter int N = 3
) (
    input wire logic [N-1:0] pend,
    output logic any,
    output logic [1:0] chan
);
    always_comb begin
        any = |pend;
        chan = 2'h0;
        // lowest index wins, local channel sits at index 0
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                chan = 2'(i);
            end
        end
    end
endmodule

`default_nettype wire

//--- hdl/tcs_params.svh
// constants of the temperature conversion scheduler
// assumes a single 200 MHz clock domain and an includer that uses these macros
// Overview of operation
// - each channel refreshed every five milliseconds
// - finished integration raises a conversion request
// - single mode: convert after current conversion
// - sequenced mode: insert at sequence slot
// - idle converter: start temperature conversion immediately
// - one result register per temperature channel
// - single mode may return remote results
// - add signed offset before storing result
// - four DAC channels with 12-bit codes
// - invert each DAC code before core
// - above 150 degrees DAC outputs high-impedance
// - thermal shutdown sets overtemperature alert bit
// - shutdown inactive while sensor powered down
// - overcurrent comparator trip drives flag high
// - supply below analog level also trips
// - flag latched until host clears it
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define TCS_CLK_MHZ 200
`define TCS_PERIOD_MS 5
`define TCS_PERIOD_CYC (`TCS_PERIOD_MS * `TCS_CLK_MHZ * 1000)

// ****************************************************************
// widths and counts
// ****************************************************************
`define TCS_NUM_TEMP 3
`define TCS_NUM_DAC 4
`define TCS_DAC_W 12
`define TCS_TEMP_W 12
`define TCS_NUM_OC 2

// ****************************************************************
// temperature format and thermal limit
// ****************************************************************
`define TCS_LSB_PER_DEGC 4
`define TCS_TSD_DEGC 150
`define TCS_TSD_CODE (`TCS_TSD_DEGC * `TCS_LSB_PER_DEGC)
`define TCS_TEMP_MAX 12'h7FF
`define TCS_TEMP_MIN 12'h800

// ****************************************************************
// reset values
// ****************************************************************
`define TCS_RESULT_RST 12'h000
`define TCS_DAC_RST 12'h000

`endif

//--- hdl/tcs_pkg.sv
// types shared by the temperature conversion scheduler
// assumes tcs_params.svh is on the include path
`default_nettype none
`include "tcs_params.svh"

package tcs_pkg;

    // ****************************************************************
    // converter modes and scheduler states
    // ****************************************************************
    typedef enum logic [0:0] {
        ADC_MODE_SINGLE = 1'b0,
        ADC_MODE_SEQ = 1'b1
    } tcs_mode_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } tcs_state_type;

    typedef logic [1:0] tcs_chan_type;
    typedef logic [`TCS_TEMP_W-1:0] tcs_temp_type;
    typedef logic [`TCS_DAC_W-1:0] tcs_dac_type;

    // ****************************************************************
    // converter handshake carriers
    // ****************************************************************
    typedef struct packed {
        logic start;
        tcs_chan_type chan;
    } tcs_conv_req_type;

    typedef struct packed {
        logic done;
        tcs_chan_type chan;
        tcs_temp_type data;
    } tcs_conv_rsp_type;

    typedef struct packed {
        logic busy;
        logic conv_done;
        logic seq_slot;
        tcs_mode_type mode;
    } tcs_adc_stat_type;

    // ****************************************************************
    // whole state of the top module
    // ****************************************************************
    typedef struct packed {
        tcs_state_type st;
        logic [31:0] slot_cnt;
        tcs_chan_type integ_ch;
        logic [`TCS_NUM_TEMP-1:0] pend;
        tcs_conv_req_type req;
        logic [`TCS_NUM_TEMP-1:0][`TCS_TEMP_W-1:0] res;
        logic [`TCS_NUM_DAC-1:0][`TCS_DAC_W-1:0] dac;
        logic [`TCS_NUM_OC-1:0] cmp_s1;
        logic [`TCS_NUM_OC-1:0] cmp_s2;
        logic [`TCS_NUM_OC-1:0] uv_s1;
        logic [`TCS_NUM_OC-1:0] uv_s2;
        logic [`TCS_NUM_OC-1:0] oc_flag;
        logic tsd;
        logic ot_alert;
        logic [1:0] rd_remote;
    } tcs_top_state_type;

endpackage

`default_nettype wire

//--- hdl/tcs_top.sv
// temperature conversion scheduler, DAC code path, thermal and overcurrent flags
// assumes converter control logic on sys_clk; comparator inputs are asynchronous
`default_nettype none
`include "tcs_params.svh"

module tcs_top #(
    parameter int PERIOD_CYC = `TCS_PERIOD_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire tcs_pkg::tcs_adc_stat_type adc_stat,
    output tcs_pkg::tcs_conv_req_type conv_req,
    input wire tcs_pkg::tcs_conv_rsp_type conv_rsp,
    input wire logic [`TCS_TEMP_W-1:0] temp_offset,
    output logic [`TCS_NUM_TEMP-1:0][`TCS_TEMP_W-1:0] temp_result,
    input wire logic [1:0] rd_remote_sel,
    output logic [1:0] rd_remote_en,
    input wire logic [`TCS_NUM_DAC-1:0][`TCS_DAC_W-1:0] dac_code,
    output logic [`TCS_NUM_DAC-1:0][`TCS_DAC_W-1:0] dac_core_code,
    input wire logic temp_sensor_pd,
    output logic dac_hiz,
    output logic overtemp_alert,
    input wire logic overtemp_alert_clr,
    input wire logic [`TCS_NUM_OC-1:0] oc_cmp_trip,
    input wire logic [`TCS_NUM_OC-1:0] oc_supply_low,
    input wire logic [`TCS_NUM_OC-1:0] oc_flag_clr,
    output logic [`TCS_NUM_OC-1:0] overcurrent_flag_out
);
    import tcs_pkg::*;

    localparam int SLOT_CYC = (PERIOD_CYC / `TCS_NUM_TEMP < 1) ? 1 : PERIOD_CYC / `TCS_NUM_TEMP;
    localparam logic signed [`TCS_TEMP_W:0] TSD_LIMIT = 13'(`TCS_TSD_CODE);
    localparam logic signed [`TCS_TEMP_W:0] SAT_MAX = 13'(signed'(`TCS_TEMP_MAX));
    localparam logic signed [`TCS_TEMP_W:0] SAT_MIN = 13'(signed'(`TCS_TEMP_MIN));

    tcs_top_state_type s_q;
    tcs_top_state_type s_d;
    logic arb_any;
    tcs_chan_type arb_chan;
    logic [`TCS_NUM_DAC-1:0][`TCS_DAC_W-1:0] dac_inv;
    logic signed [`TCS_TEMP_W:0] corr_sum;
    tcs_temp_type corr_val;
    logic slot_end;
    logic start_ok;
    logic store_local;
    logic tsd_over;

    // ****************************************************************
    // request arbitration
    // ****************************************************************
    tcs_arbiter #(
        .N(`TCS_NUM_TEMP)
    ) u_arb (
        .pend(s_q.pend),
        .any(arb_any),
        .chan(arb_chan)
    );

    // ****************************************************************
    // DAC code inversion, one lane per channel
    // ****************************************************************
    for (genvar g = 0; g < `TCS_NUM_DAC; g++) begin : g_dac
        assign dac_inv[g] = ~dac_code[g];
    end

    // ****************************************************************
    // offset correction with saturation
    // ****************************************************************
    always_comb begin
        // the sum is one bit wider so a large offset clamps instead of wrapping
        // clamping keeps a hot reading hot, which the thermal trip relies on
        corr_sum = $signed({conv_rsp.data[`TCS_TEMP_W-1], conv_rsp.data}) +
                   $signed({temp_offset[`TCS_TEMP_W-1], temp_offset});
        if (corr_sum > SAT_MAX) begin
            corr_val = `TCS_TEMP_MAX;
        end else if (corr_sum < SAT_MIN) begin
            corr_val = `TCS_TEMP_MIN;
        end else begin
            corr_val = corr_sum[`TCS_TEMP_W-1:0];
        end
    end

    // ****************************************************************
    // thermal limit compare
    // ****************************************************************
    // strictly above the limit; a reading of exactly the limit keeps outputs driven
    // the compare sees every result; only a local channel result reaches the shutdown bit
    always_comb begin
        tsd_over = ($signed({corr_val[`TCS_TEMP_W-1], corr_val}) > TSD_LIMIT);
    end

    // ****************************************************************
    // converter readiness
    // ****************************************************************
    // an idle converter takes a request at once; a busy one only at the
    // completion pulse in single mode or at the insertion point in a sequence
    always_comb begin
        start_ok = !adc_stat.busy ||
                   (adc_stat.mode == ADC_MODE_SINGLE && adc_stat.conv_done) ||
                   (adc_stat.mode == ADC_MODE_SEQ && adc_stat.seq_slot);
    end

    // ****************************************************************
    // integration slot timer
    // ****************************************************************
    // the period splits into one slot per channel; each slot end is one finished integration
    // a period too short for three slots still gives one cycle per slot
    always_comb begin
        slot_end = (s_q.slot_cnt == 32'(SLOT_CYC - 1));
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        store_local = 1'b0;
        s_d.req.start = 1'b0;

        // background integration walks the three inputs in turn
        if (slot_end) begin
            s_d.slot_cnt = 32'h0000_0000;
            s_d.integ_ch = (s_q.integ_ch == 2'(`TCS_NUM_TEMP - 1)) ? 2'h0 : s_q.integ_ch + 2'h1;
        end else begin
            s_d.slot_cnt = s_q.slot_cnt + 32'h0000_0001;
        end

        // one conversion outstanding: the next grant waits for this result
        case (s_q.st)
            ST_IDLE: begin
                // a request that finds the converter occupied stays pending
                if (arb_any && start_ok) begin
                    s_d.req.start = 1'b1;
                    s_d.req.chan = arb_chan;
                    s_d.pend[arb_chan] = 1'b0;
                    s_d.st = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_rsp.done) begin
                    s_d.res[conv_rsp.chan] = corr_val;
                    store_local = (conv_rsp.chan == 2'h0);
                    s_d.st = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase

        // an integration finishing in the grant cycle stays pending
        if (slot_end) begin
            s_d.pend[s_q.integ_ch] = 1'b1;
        end

        // core taps count the other way, so the inverted code is registered
        for (int i = 0; i < `TCS_NUM_DAC; i++) begin
            s_d.dac[i] = dac_inv[i];
        end

        // remote registers join the read sequence only in single mode
        s_d.rd_remote = (adc_stat.mode == ADC_MODE_SINGLE) ? rd_remote_sel : 2'h0;

        // thermal shutdown follows each fresh local result
        if (temp_sensor_pd) begin
            s_d.tsd = 1'b0;
        end else if (store_local) begin
            s_d.tsd = tsd_over;
        end
        // set wins: a clear while shutdown lasts leaves the alert up
        s_d.ot_alert = s_d.tsd || (s_q.ot_alert && !overtemp_alert_clr);

        // comparator inputs pass two flops before use
        s_d.cmp_s1 = oc_cmp_trip;
        s_d.cmp_s2 = s_q.cmp_s1;
        s_d.uv_s1 = oc_supply_low;
        s_d.uv_s2 = s_q.uv_s1;
        // a trip that meets a clear in one cycle keeps its flag
        s_d.oc_flag = s_q.cmp_s2 |
                      s_q.uv_s2 |
                      (s_q.oc_flag & ~oc_flag_clr);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q.st <= ST_IDLE;
            s_q.slot_cnt <= 32'h0000_0000;
            s_q.integ_ch <= 2'h0;
            s_q.pend <= 3'h0;
            s_q.req <= '0;
            s_q.res <= {`TCS_NUM_TEMP{`TCS_RESULT_RST}};
            // core codes read zero until the first edge after release
            s_q.dac <= {`TCS_NUM_DAC{`TCS_DAC_RST}};
            s_q.cmp_s1 <= 2'h0;
            s_q.cmp_s2 <= 2'h0;
            s_q.uv_s1 <= 2'h0;
            s_q.uv_s2 <= 2'h0;
            s_q.oc_flag <= 2'h0;
            s_q.tsd <= 1'b0;
            s_q.ot_alert <= 1'b0;
            s_q.rd_remote <= 2'h0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // every output comes straight from a register, so none glitches
    assign conv_req = s_q.req;
    assign temp_result = s_q.res;
    assign rd_remote_en = s_q.rd_remote;
    assign dac_core_code = s_q.dac;
    assign dac_hiz = s_q.tsd;
    assign overtemp_alert = s_q.ot_alert;
    assign overcurrent_flag_out = s_q.oc_flag;

endmodule

`default_nettype wire
